// ### verilog/ext_bus_pkg.sv
// constants for the external memory bus interface
package ext_bus_pkg;
    localparam int          OSC_PER_CYCLE    = 6;
    localparam logic [2:0]  PH_ALE_HI        = 3'h0;
    localparam logic [2:0]  PH_ALE_LO        = 3'h1;
    localparam logic [2:0]  PH_STROBE        = 3'h2;
    localparam logic [2:0]  PH_LAST          = 3'h5;
    localparam logic [15:0] INT_CODE_TOP     = 16'h1FFF;
    localparam int          ALE_OFF_BIT      = 4;
    localparam logic [7:0]  POWER_CONTROL_REG_RESET       = 8'h00;
    localparam logic [7:0]  PORT_RESET       = 8'hFF;
endpackage : ext_bus_pkg

// ### verilog/ext_mem_bus.sv
// external memory bus interface: address latch, strobes, muxed port
`timescale 1ns/10ps
`default_nettype none
module ext_mem_bus
    import ext_bus_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        external_access_select,
    input  wire logic        pstore_pin_in,
    input  wire logic [7:0]  mux_addr_data_lines_in,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        data_req,
    input  wire logic        data_we,
    input  wire logic        data_wide,
    input  wire logic [7:0]  pointer_page_byte,
    input  wire logic [7:0]  pointer_high_byte,
    input  wire logic [7:0]  pointer_low_byte,
    input  wire logic [7:0]  data_wr,
    input  wire logic [7:0]  power_control_reg,
    input  wire logic [7:0]  low_port_latch,
    input  wire logic [7:0]  high_port_latch,
    output logic             fetch_external,
    output logic             download_mode,
    output logic             data_busy,
    output logic             data_done,
    output logic [7:0]       data_rd,
    output logic             fetch_done,
    output logic [7:0]       fetch_data,
    output logic             addr_latch_strobe,
    output logic             program_store_strobe_out,
    output logic             program_store_strobe_oe,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic [7:0]       low_addr_data_port_out,
    output logic [7:0]       low_addr_data_port_oe,
    output logic [7:0]       high_addr_port_out,
    output logic [7:0]       high_addr_port_oe
);
    typedef enum logic [1:0] {
        ST_BOOT  = 2'b00,
        ST_FETCH = 2'b01,
        ST_DATA  = 2'b10
    } cyc_e;

    cyc_e        state;
    cyc_e        next_state;
    logic [2:0]  phase;
    logic        boot_done;
    logic        ea_ff1;
    logic        ea_ff2;
    logic        ps_ff1;
    logic        ps_ff2;
    logic [7:0]  ad_ff1;
    logic [7:0]  ad_ff2;
    logic        we_q;
    logic [7:0]  wr_q;
    logic [15:0] daddr_q;
    logic [7:0]  dpage_q;
    logic        wide_q;

    // pins are asynchronous to mclk: two stages before use
    always_ff @(posedge mclk) begin
        ea_ff1 <= external_access_select;
        ea_ff2 <= ea_ff1;
        ps_ff1 <= pstore_pin_in;
        ps_ff2 <= ps_ff1;
        ad_ff1 <= mux_addr_data_lines_in;
        ad_ff2 <= ad_ff1;
    end

    wire fetch_is_internal = !fetch_external && (fetch_addr <= INT_CODE_TOP);
    wire ale_enable        = !power_control_reg[ALE_OFF_BIT];
    wire last_phase        = (phase == PH_LAST);
    wire accept_data       = (state == ST_FETCH) && last_phase && data_req;
    wire [7:0] hi_fetch    = fetch_addr[15:8];
    wire [7:0] hi_data     = wide_q ? dpage_q : daddr_q[15:8];
    wire in_cycle          = (state != ST_BOOT) && !(state == ST_FETCH && fetch_is_internal);
    // port values are registered one phase ahead, so the address stands in phases 0 and 1
    wire addr_phase        = last_phase || (phase == PH_ALE_HI);
    wire drive_bus         = in_cycle || (next_state == ST_DATA);
    wire [7:0] hi_accept   = data_wide ? pointer_page_byte : pointer_high_byte;
    wire [7:0] hi_next     = (next_state == ST_DATA)
                             ? (accept_data ? hi_accept : hi_data) : hi_fetch;
    wire [7:0] lo_next     = (next_state == ST_DATA)
                             ? (accept_data ? pointer_low_byte : daddr_q[7:0]) : fetch_addr[7:0];

    always_comb begin
        next_state = state;
        case (state)
            ST_BOOT:  next_state = boot_done ? ST_FETCH : ST_BOOT;
            ST_FETCH: next_state = accept_data ? ST_DATA : ST_FETCH;
            ST_DATA:  next_state = last_phase ? ST_FETCH : ST_DATA;
            default:  next_state = ST_BOOT;
        endcase
    end

    // mode pins caught one cycle after reset release, then frozen
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_done      <= 1'b0;
            fetch_external <= 1'b0;
            download_mode  <= 1'b0;
        end else if (!boot_done) begin
            boot_done      <= 1'b1;
            fetch_external <= !ea_ff2;
            download_mode  <= !ps_ff2;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_BOOT;
            phase <= PH_ALE_HI;
        end else begin
            state <= next_state;
            phase <= (state == ST_BOOT || last_phase) ? PH_ALE_HI : phase + 3'h1;
        end
    end

    // data request captured at the cycle boundary
    always_ff @(posedge mclk) begin
        if (rst) begin
            we_q    <= 1'b0;
            wr_q    <= 8'h00;
            daddr_q <= 16'h0000;
            dpage_q <= 8'h00;
            wide_q  <= 1'b0;
        end else if (accept_data) begin
            we_q    <= data_we;
            wr_q    <= data_wr;
            daddr_q <= {pointer_high_byte, pointer_low_byte};
            dpage_q <= pointer_page_byte;
            wide_q  <= data_wide;
        end
    end

    // strobes and ports: all outputs registered
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_latch_strobe        <= 1'b0;
            program_store_strobe_out <= 1'b1;
            program_store_strobe_oe  <= 1'b0;
            read_strobe_n            <= 1'b1;
            write_strobe_n           <= 1'b1;
            low_addr_data_port_out   <= PORT_RESET;
            low_addr_data_port_oe    <= 8'h00;
            high_addr_port_out       <= PORT_RESET;
            high_addr_port_oe        <= 8'h00;
            data_busy                <= 1'b0;
            data_done                <= 1'b0;
            data_rd                  <= 8'h00;
            fetch_done               <= 1'b0;
            fetch_data               <= 8'h00;
        end else begin
            program_store_strobe_oe <= (state != ST_BOOT);
            data_busy  <= (next_state == ST_DATA);
            data_done  <= (state == ST_DATA) && last_phase;
            fetch_done <= (state == ST_FETCH) && last_phase && !fetch_is_internal;
            if (state == ST_FETCH && last_phase && !fetch_is_internal) begin
                fetch_data <= ad_ff2;
            end
            if (state == ST_DATA && last_phase && !we_q) begin
                data_rd <= ad_ff2;
            end
            // latch strobe high in phase 0 of every external fetch but the first after boot, also after a data cycle
            addr_latch_strobe <= ale_enable && last_phase && (next_state == ST_FETCH)
                                 && !fetch_is_internal;
            program_store_strobe_out <= !(state == ST_FETCH && in_cycle
                                        && phase >= PH_STROBE && phase < PH_LAST);
            read_strobe_n  <= !(state == ST_DATA && !we_q && phase >= PH_STROBE
                              && phase < PH_LAST);
            write_strobe_n <= !(state == ST_DATA && we_q && phase >= PH_STROBE
                              && phase < PH_LAST);
            if (drive_bus) begin
                high_addr_port_out <= hi_next;
                high_addr_port_oe  <= 8'hFF;
                low_addr_data_port_out <= addr_phase ? lo_next : wr_q;
                // strong drive of ones and zeros in address phases and for write data while acting as bus, released for fetch and read data
                low_addr_data_port_oe <= (addr_phase || (state == ST_DATA && we_q))
                                         ? 8'hFF : 8'h00;
            end else begin
                high_addr_port_out     <= high_port_latch;
                high_addr_port_oe      <= ~high_port_latch;
                low_addr_data_port_out <= 8'h00;
                low_addr_data_port_oe  <= ~low_port_latch;
            end
        end
    end

    // note: the latch strobe is registered from phase 5 so it is high in phase 0
    a_strobes_exclusive: assert property (@(posedge mclk) disable iff (rst)
        !(!read_strobe_n && !write_strobe_n))
        else $error("read and write strobes both active");
    a_read_no_pstore: assert property (@(posedge mclk) disable iff (rst)
        !read_strobe_n |-> program_store_strobe_out)
        else $error("program strobe during data read");
    a_internal_pstore: assert property (@(posedge mclk) disable iff (rst)
        (boot_done && !fetch_external && state == ST_FETCH && fetch_is_internal
         && phase == PH_ALE_LO) |=> program_store_strobe_out [*3])
        else $error("program strobe active during internal fetch");
    a_ale_off: assert property (@(posedge mclk) disable iff (rst)
        power_control_reg[ALE_OFF_BIT] |=> !addr_latch_strobe)
        else $error("latch strobe while disabled");
    a_ale_before: assert property (@(posedge mclk) disable iff (rst)
        $fell(program_store_strobe_out) |-> $past(!addr_latch_strobe))
        else $error("program strobe before latch strobe fell");
    a_wr_data_out: assert property (@(posedge mclk) disable iff (rst)
        !write_strobe_n |-> low_addr_data_port_oe == 8'hFF)
        else $error("write strobe without data drive");
    a_rd_release: assert property (@(posedge mclk) disable iff (rst)
        !read_strobe_n |-> low_addr_data_port_oe == 8'h00)
        else $error("low port driven during read");
    a_mode_frozen: assert property (@(posedge mclk) disable iff (rst)
        boot_done |=> $stable(fetch_external) && $stable(download_mode))
        else $error("boot mode changed after capture");
    a_pstore_period: assert property (@(posedge mclk) disable iff (rst)
        $fell(program_store_strobe_out) && state == ST_FETCH && !accept_data
        && !fetch_is_internal |-> ##6 (program_store_strobe_out == 1'b0 || state != ST_FETCH))
        else $error("program strobe period not six");

    a_ale_one_phase: assert property (@(posedge mclk) disable iff (rst)
        addr_latch_strobe |=> !addr_latch_strobe)
        else $error("latch strobe longer than one phase");

    a_ale_phase0: assert property (@(posedge mclk) disable iff (rst)
        addr_latch_strobe |-> phase == PH_ALE_HI)
        else $error("latch strobe outside phase 0");

    a_ale_no_data: assert property (@(posedge mclk) disable iff (rst)
        addr_latch_strobe |-> state == ST_FETCH)
        else $error("latch strobe in data cycle");

    a_ale_addr_drive: assert property (@(posedge mclk) disable iff (rst)
        addr_latch_strobe |-> low_addr_data_port_oe == 8'hFF)
        else $error("low port not driven under latch strobe");

    a_ale_low_addr: assert property (@(posedge mclk) disable iff (rst)
        addr_latch_strobe |-> low_addr_data_port_out == $past(fetch_addr[7:0]))
        else $error("wrong low address under latch strobe");

    a_ale_high_addr: assert property (@(posedge mclk) disable iff (rst)
        addr_latch_strobe |-> high_addr_port_out == $past(fetch_addr[15:8]))
        else $error("wrong high address under latch strobe");

    a_pstore_len: assert property (@(posedge mclk) disable iff (rst)
        $fell(program_store_strobe_out) |=> !program_store_strobe_out [*2])
        else $error("program strobe too short");

    a_pstore_rise: assert property (@(posedge mclk) disable iff (rst)
        $fell(program_store_strobe_out) |-> ##3 program_store_strobe_out)
        else $error("program strobe too long");

    a_pstore_fetch: assert property (@(posedge mclk) disable iff (rst)
        !program_store_strobe_out |-> state == ST_FETCH)
        else $error("program strobe outside fetch cycle");

    a_pstore_alone: assert property (@(posedge mclk) disable iff (rst)
        !program_store_strobe_out |-> read_strobe_n && write_strobe_n)
        else $error("program strobe with data strobe");

    a_rd_len: assert property (@(posedge mclk) disable iff (rst)
        $fell(read_strobe_n) |=> !read_strobe_n [*2])
        else $error("read strobe too short");

    a_wr_len: assert property (@(posedge mclk) disable iff (rst)
        $fell(write_strobe_n) |=> !write_strobe_n [*2])
        else $error("write strobe too short");

    a_rd_in_data: assert property (@(posedge mclk) disable iff (rst)
        !read_strobe_n |-> state == ST_DATA)
        else $error("read strobe outside data cycle");

    a_wr_in_data: assert property (@(posedge mclk) disable iff (rst)
        !write_strobe_n |-> state == ST_DATA)
        else $error("write strobe outside data cycle");

    a_wr_value: assert property (@(posedge mclk) disable iff (rst)
        !write_strobe_n |-> low_addr_data_port_out == wr_q)
        else $error("write strobe without write byte");

    a_strobe_phase: assert property (@(posedge mclk) disable iff (rst)
        ($fell(read_strobe_n) || $fell(write_strobe_n) || $fell(program_store_strobe_out))
        |-> phase == PH_STROBE + 3'h1)
        else $error("strobe fell in wrong phase");

    a_ale_gap: assert property (@(posedge mclk) disable iff (rst)
        addr_latch_strobe |=> ##1 (program_store_strobe_out && read_strobe_n && write_strobe_n))
        else $error("strobe too close to latch strobe");

    a_data_hi_wide: assert property (@(posedge mclk) disable iff (rst)
        (!read_strobe_n || !write_strobe_n) && wide_q |-> high_addr_port_out == dpage_q)
        else $error("page byte missing on high port");

    a_data_hi_narrow: assert property (@(posedge mclk) disable iff (rst)
        (!read_strobe_n || !write_strobe_n) && !wide_q |-> high_addr_port_out == daddr_q[15:8])
        else $error("high byte missing on high port");

    a_done_pulse: assert property (@(posedge mclk) disable iff (rst)
        data_done |=> !data_done)
        else $error("data done longer than one cycle");

    a_fetch_pulse: assert property (@(posedge mclk) disable iff (rst)
        fetch_done |=> !fetch_done)
        else $error("fetch done longer than one cycle");

    a_busy_data: assert property (@(posedge mclk) disable iff (rst)
        data_busy |-> state == ST_DATA)
        else $error("busy outside data cycle");

    a_boot_quiet: assert property (@(posedge mclk) disable iff (rst)
        state == ST_BOOT |-> program_store_strobe_out && read_strobe_n && write_strobe_n
        && !addr_latch_strobe)
        else $error("strobe active before mode capture");

    a_phase_range: assert property (@(posedge mclk) disable iff (rst)
        phase <= PH_LAST)
        else $error("phase beyond cycle end");

    a_hi_drive: assert property (@(posedge mclk) disable iff (rst)
        !program_store_strobe_out |-> high_addr_port_oe == 8'hFF)
        else $error("high port not driven during fetch");

    a_fetch_release: assert property (@(posedge mclk) disable iff (rst)
        !program_store_strobe_out |-> low_addr_data_port_oe == 8'h00)
        else $error("low port driven while memory drives");

    a_pstore_oe: assert property (@(posedge mclk) disable iff (rst)
        state != ST_BOOT |=> program_store_strobe_oe)
        else $error("program strobe pin not driven after boot");
endmodule : ext_mem_bus
`default_nettype wire

// ### bench/ext_mem_model.sv
// behavioural external program and data memory with its address latch
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
    input  wire logic       mclk,
    input  wire logic       ale,
    input  wire logic       ps_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] port_out,
    input  wire logic [7:0] port_oe,
    input  wire logic [7:0] high,
    output logic      [7:0] pin,
    output logic      [7:0] last_wr
);
    logic [7:0] lat;
    logic       en;
    logic [7:0] drv;
    // low byte held from the latch strobe, as an external latch part would
    always_ff @(posedge mclk) begin
        if (ale) begin
            lat <= pin;
        end
        if (!wr_n) begin
            last_wr <= pin;
        end
    end
    assign en  = !ps_n || !rd_n;
    assign drv = !ps_n ? (high ^ lat ^ 8'hA5) : (high ^ 8'h3C);
    // released lines take the memory byte while ps_n or rd_n is low, else float up to the board pull-up, never the last value
    assign pin = (port_oe & port_out) | (~port_oe & (en ? drv : 8'hFF));
endmodule : ext_mem_model
`default_nettype wire

// ### bench/external_memory_bus_interface_bench.sv
// self-checking bench for the external memory bus interface
`timescale 1ns/10ps
`default_nettype none
module external_memory_bus_interface_bench;
    import ext_bus_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        external_access_select = 1'b0;
    logic        ps_pull = 1'b1;
    logic [15:0] fetch_addr = 16'h2345;
    logic        data_req = 1'b0, data_we = 1'b0, data_wide = 1'b0;
    logic [7:0]  pointer_page_byte = 8'h00, pointer_high_byte = 8'h00;
    logic [7:0]  pointer_low_byte = 8'h56, data_wr = 8'h00;
    logic [7:0]  power_control_reg = POWER_CONTROL_REG_RESET;
    logic [7:0]  low_port_latch = PORT_RESET, high_port_latch = PORT_RESET;
    logic        fetch_external, download_mode, data_busy, data_done, fetch_done;
    logic        addr_latch_strobe, program_store_strobe_out, program_store_strobe_oe;
    logic        read_strobe_n, write_strobe_n;
    logic [7:0]  data_rd, fetch_data, low_addr_data_port_out, low_addr_data_port_oe;
    logic [7:0]  high_addr_port_out, high_addr_port_oe, mux_addr_data_lines_in, last_wr;
    wire logic   pstore_pin_in;
    int          error_cnt = 0, n_compared = 0, n;
    // boot resistor decides the pin only while the block lets go of it
    assign pstore_pin_in = program_store_strobe_oe ? program_store_strobe_out : ps_pull;
    always #20 mclk = ~mclk;
    ext_mem_bus dut (.*);
    ext_mem_model mem (.mclk(mclk), .ale(addr_latch_strobe), .ps_n(pstore_pin_in),
        .rd_n(read_strobe_n), .wr_n(write_strobe_n), .port_out(low_addr_data_port_out),
        .port_oe(low_addr_data_port_oe), .high(high_addr_port_out),
        .pin(mux_addr_data_lines_in), .last_wr(last_wr));
    task automatic end_sim;
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk
    function automatic logic hit(input int k);
        case (k)
            0: return fetch_done === 1'b1;
            1: return write_strobe_n === 1'b0;
            2: return read_strobe_n === 1'b0;
            3: return data_done === 1'b1;
            4: return data_busy === 1'b1;
            5: return program_store_strobe_out === 1'b0;
            6: return addr_latch_strobe === 1'b1;
            default: return addr_latch_strobe === 1'b0;
        endcase
    endfunction : hit
    task automatic wait_for(input int k);
        int i;
        i = 0;
        while (!hit(k) && i < 200) begin
            @(negedge mclk);
            i++;
        end
        if (!hit(k)) begin
            $display("wrong value wait %0d expected 1 seen 0", k);
            error_cnt++;
            end_sim();
        end
    endtask : wait_for
    // select only moves while reset is held
    task automatic do_reset(input logic sel, input logic pull);
        @(negedge mclk);
        rst = 1'b1;
        external_access_select = sel;
        ps_pull = pull;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
    endtask : do_reset
    task automatic t_fetch;
        do_reset(1'b0, 1'b1);
        chk("external mode", 1, fetch_external);
        chk("download mode", 0, download_mode);
        wait_for(0);
        @(negedge mclk);
        wait_for(0);
        chk("fetch data", 8'h23 ^ 8'h45 ^ 8'hA5, fetch_data);
        wait_for(5);
        chk("fetch high addr", 8'h23, high_addr_port_out);
        chk("fetch high oe", 8'hFF, high_addr_port_oe);
        chk("latch at program strobe", 0, addr_latch_strobe);
        chk("rd wr at fetch", 2'b11, {read_strobe_n, write_strobe_n});
        wait_for(7);
        wait_for(6);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!hit(6) && n < 20);
        chk("latch period", OSC_PER_CYCLE, n[15:0]);
    endtask : t_fetch
    task automatic start_data(input logic we, input logic wide);
        data_we = we;
        data_wide = wide;
        data_req = 1'b1;
        wait_for(4);
        data_req = 1'b0;
    endtask : start_data
    task automatic t_write;
        pointer_page_byte = 8'h12;
        pointer_high_byte = 8'h34;
        data_wr = 8'hC3;
        start_data(1'b1, 1'b1);
        wait_for(1);
        chk("write page", 8'h12, high_addr_port_out);
        chk("write data", 8'hC3, low_addr_data_port_out);
        chk("write oe", 8'hFF, low_addr_data_port_oe);
        chk("pstore in write", 1, program_store_strobe_out);
        chk("latch in write", 0, addr_latch_strobe);
        wait_for(3);
        chk("stored byte", 8'hC3, last_wr);
    endtask : t_write
    task automatic t_read;
        pointer_high_byte = 8'h9A;
        start_data(1'b0, 1'b0);
        wait_for(2);
        chk("read high", 8'h9A, high_addr_port_out);
        chk("read oe", 8'h00, low_addr_data_port_oe);
        wait_for(3);
        chk("read data", 8'h9A ^ 8'h3C, data_rd);
    endtask : t_read
    task automatic t_latch_off;
        power_control_reg[ALE_OFF_BIT] = 1'b1;
        n = 0;
        repeat (18) begin
            @(negedge mclk);
            if (addr_latch_strobe !== 1'b0) n++;
        end
        chk("latch while off", 0, n[15:0]);
        power_control_reg = POWER_CONTROL_REG_RESET;
        wait_for(6);
    endtask : t_latch_off
    task automatic t_internal;
        fetch_addr = 16'h0100;
        low_port_latch = 8'hA5;
        high_port_latch = 8'h3C;
        do_reset(1'b1, 1'b0);
        chk("internal mode", 0, fetch_external);
        chk("download entry", 1, download_mode);
        n = 0;
        repeat (24) begin
            @(negedge mclk);
            if (program_store_strobe_out !== 1'b1) n++;
        end
        chk("pstore idle", 0, n[15:0]);
        chk("low port float", 8'h5A, low_addr_data_port_oe);
        chk("high port latch", 8'h3C, high_addr_port_out);
        chk("high port pullup", 8'hC3, high_addr_port_oe);
        chk("pstore oe", 1, program_store_strobe_oe);
    endtask : t_internal
    initial begin
        t_fetch();
        t_write();
        t_read();
        t_latch_off();
        t_internal();
        end_sim();
    end
endmodule : external_memory_bus_interface_bench
`default_nettype wire
